// ===== tb_vsu_shift_unit.sv
// Self-checking bench for the vector shift unit
`timescale 1ns/10ps
`default_nettype none
module tb_vsu_shift_unit;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        go = 1'b0;
    logic        pf = 1'b0;
    logic [1:0]  op = 2'h0;
    logic [2:0]  k = 3'h0;
    logic [7:0]  vl = 8'h00;
    logic [63:0] ak = 64'h0;
    logic        v0, v1, m0, m1, o0, o1, rdy, bsy, nof, r0v, r1v, fin;
    logic [63:0] d0, d1, c0, c1, q0, q1;
    logic [7:0]  i0, i1, sc;
    logic [31:0] rv;
    logic [71:0] exq [$];
    int          miscompares = 0;
    int          samples_checked = 0;
    int          seed = 16952;
    int          t;
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    vsu_shift_unit vsu_shift_unit_i (
        .core_clk(core_clk), .rst(rst), .ce(ce), .go(go),
        .extended_instruction_prefix(pf), .op_sel(op), .k_field(k),
        .vec_len(vl), .address_count_register(ak),
        .source_vector_p0_valid(v0), .source_vector_p0(d0),
        .source_vector_p1_valid(v1), .source_vector_p1(d1),
        .mask_even(m0), .mask_odd(m1),
        .vector_count_register_p0(c0), .vector_count_ovf_p0(o0),
        .vector_count_register_p1(c1), .vector_count_ovf_p1(o1),
        .in_ready(rdy), .busy(bsy), .no_ak_overflow(nof),
        .res_p0_valid(r0v), .destination_vector_p0(q0), .res_p0_idx(i0),
        .res_p1_valid(r1v), .destination_vector_p1(q1), .res_p1_idx(i1),
        .src_count(sc), .shift_end(fin));
    vsu_supplier vsu_supplier_i (
        .core_clk(core_clk), .go(go), .busy(bsy), .in_ready(rdy), .vl(vl),
        .src_count(sc), .p0_valid(v0), .p0(d0), .p1_valid(v1), .p1(d1),
        .mask_even(m0), .mask_odd(m1), .vc0(c0), .ovf0(o0), .vc1(c1),
        .ovf1(o1));
    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [71:0] pop();
        if (exq.size() == 0)
            return 72'hX;
        return exq.pop_front();
    endfunction : pop
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    // Each result pulse retires the oldest note, pipe 0 before pipe 1
    always @(posedge core_clk) begin
        #2;
        if (r0v === 1'b1)
            check({i0, q0}, pop());
        if (r1v === 1'b1)
            check({i1, q1}, pop());
    end
    task automatic run_op(input logic p, input logic [1:0] o,
                          input logic [2:0] kk, input int n,
                          input logic [63:0] a);
        logic [63:0] e [0:130];
        logic [63:0] cn, r, nx, pv;
        logic        vm, cm, xp, mk;
        int          c, s, j;
        vm = p && !o[1] && kk == 3'h0;
        cm = p && o == 2'h3 && !kk[0];
        xp = p && o == 2'h3 && kk[0];
        s = 0;
        for (j = 0; j < 131; j++) begin
            e[j] = {$random(seed), $random(seed)};
            vsu_supplier_i.mem[j] = e[j];
            vsu_supplier_i.msk[j] = 1'($random(seed));
            vsu_supplier_i.vc[j] = j == 3 ? 64'h200
                                          : 64'(7'($random(seed)));
        end
        for (j = 0; j < n; j++) begin
            mk = vsu_supplier_i.msk[j];
            nx = j + 1 < n ? e[j + 1] : 64'h0;
            pv = j > 0 ? e[j - 1] : 64'h0;
            cn = vm ? vsu_supplier_i.vc[j] : a;
            c  = o[1] ? int'(cn[6:0]) : int'(cn[5:0]);
            case (o)
                2'h0: r = e[j] << c;
                2'h1: r = e[j] >> c;
                2'h2: r = 64'(({e[j], nx} << c) >> 64);
                default: r = 64'({pv, e[j]} >> c);
            endcase
            if (cn[63:7] != 57'h0 || c == 0 || (vm && j == 4))
                r = 64'h0;
            if (p && o == 2'h2)
                r = e[j];
            if (xp || cm)
                r = mk ? e[xp ? s : j] : 64'h0;
            if (!cm || mk)
                exq.push_back({8'(cm ? s : j), r});
            s += int'(mk);
        end
        vsu_supplier_i.ovf_on = vm;
        vsu_supplier_i.expand = xp;
        @(posedge core_clk);
        #1;
        go = 1'b1;
        pf = p;
        op = o;
        k = kk;
        vl = 8'(n);
        ak = a;
        @(posedge core_clk);
        #1;
        go = 1'b0;
        for (j = 0; j < 300 && fin !== 1'b1; j++) begin
            @(posedge core_clk);
            #3;
        end
        check({71'h0, fin}, 72'h1);
        check({71'h0, nof}, {71'h0, a[63:7] == 57'h0});
        @(posedge core_clk);
        #3;
        check(72'(exq.size()), 72'h0);
    endtask : run_op
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
        run_op(1'b0, 2'h0, 3'h0, 5, 64'h17);
        run_op(1'b0, 2'h1, 3'h0, 4, 64'h1);
        run_op(1'b0, 2'h0, 3'h0, 3, 64'h43);
        run_op(1'b0, 2'h1, 3'h0, 2, 64'h0);
        run_op(1'b0, 2'h0, 3'h0, 3, 64'h85);
        run_op(1'b0, 2'h2, 3'h0, 3, 64'h7F);
        run_op(1'b0, 2'h2, 3'h0, 4, 64'h45);
        run_op(1'b0, 2'h3, 3'h0, 5, 64'h9);
        run_op(1'b0, 2'h3, 3'h0, 2, 64'h40);
        run_op(1'b1, 2'h0, 3'h0, 7, 64'h1);
        run_op(1'b1, 2'h1, 3'h0, 6, 64'h0);
        run_op(1'b1, 2'h2, 3'h0, 5, 64'h0);
        run_op(1'b1, 2'h3, 3'h0, 9, 64'h0);
        run_op(1'b1, 2'h3, 3'h1, 9, 64'h0);
        run_op(1'b0, 2'h0, 3'h0, 0, 64'h5);
        run_op(1'b0, 2'h2, 3'h0, 128, 64'h100);
        for (t = 0; t < 8; t++) begin
            rv = $random(seed);
            run_op(1'b0, rv[1:0], 3'h0, 1 + int'(rv[6:2]),
                   64'(rv[13:7]));
        end
        print_verdict();
    end
endmodule : tb_vsu_shift_unit
`default_nettype wire

// ===== vsu_left_shifter.sv
// Left-only shifter: returns the top element slot of the shifted window
`timescale 1ns/10ps
`default_nettype none
module vsu_left_shifter (
    input  wire logic [vsu_pkg::WIN_W-1:0]  window,
    input  wire logic [vsu_pkg::CNT_W-1:0]  amount,
    output logic      [vsu_pkg::DATA_W-1:0] upper
);
    logic [vsu_pkg::WIN_W-1:0] shifted;

    assign shifted = window << amount;
    assign upper   = shifted[vsu_pkg::WIN_W-1:vsu_pkg::WIN_W-vsu_pkg::DATA_W];
endmodule : vsu_left_shifter
`default_nettype wire

// ===== vsu_pkg.sv
// Shared constants and types for the vector shift unit
`default_nettype none
package vsu_pkg;
    localparam int DATA_W  = 64;   // Element width
    localparam int WIN_W   = 192;  // Shifter window: three element slots
    localparam int CNT_W   = 7;    // Count field, bits 0..6
    localparam int SGL_W   = 6;    // Single shifts use bits 0..5
    localparam int OVS_LSB = 7;    // First bit that means overshift
    localparam int VL_W    = 8;    // Vector length 0..128
    localparam logic [1:0] OP_LEFT_SGL  = 2'h0;
    localparam logic [1:0] OP_RIGHT_SGL = 2'h1;
    localparam logic [1:0] OP_LEFT_DBL  = 2'h2;
    localparam logic [1:0] OP_RIGHT_DBL = 2'h3;
    localparam logic [2:0] K_ZERO       = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_FLUSH = 3'b100
    } vsu_state_t;

    typedef enum logic [2:0] {
        MD_LSH  = 3'h0,
        MD_RSH  = 3'h1,
        MD_LDBL = 3'h2,
        MD_RDBL = 3'h3,
        MD_XFER = 3'h4,
        MD_CMPR = 3'h5,
        MD_EXPD = 3'h6
    } vsu_mode_t;
endpackage : vsu_pkg
`default_nettype wire

// ===== vsu_shift_unit.sv
// Dual-pipe vector shift, transfer, compress and expand unit
//
// Functional notes
// RULE1: Address count bits above six mean overshift
// RULE2: Flag no overflow when address count fits
// RULE3: Supplier passes only count bits zero..six
// RULE4: Singles use bits 0-5, doubles add bit 6
// RULE5: Count bits weigh 1..64, shift is sum
// RULE6: Counts reach 127 places at most
// RULE7: Zero count yields an all-zero element
// RULE8: Only left shifter; right via complement count
// RULE9: Vector counts arrive separately per pipe
// RULE10: Double right shifts concatenated pair, keeps low
// RULE11: First double right pairs element zero with zeros
// RULE12: Later pairs previous high, current low
// RULE13: Compress packs masked sources from counters zero
// RULE14: Expand source counter lags on clear bits
// RULE15: Separate result valid strobe per pipe
// RULE16: Signal end of vector shift operation
// RULE17: Issue gives go strobe and prefix flag
// RULE18: Pairs in, pairs out; odd tail single
// RULE19: Count bit seven or higher zeroes result
// RULE20: Vector count overflow zeroes that pipe
`timescale 1ns/10ps
`default_nettype none
module vsu_shift_unit (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    input  wire logic                        go,
    input  wire logic                        extended_instruction_prefix,
    input  wire logic [1:0]                  op_sel,
    input  wire logic [2:0]                  k_field,
    input  wire logic [vsu_pkg::VL_W-1:0]    vec_len,
    input  wire logic [vsu_pkg::DATA_W-1:0]  address_count_register,
    input  wire logic                        source_vector_p0_valid,
    input  wire logic [vsu_pkg::DATA_W-1:0]  source_vector_p0,
    input  wire logic                        source_vector_p1_valid,
    input  wire logic [vsu_pkg::DATA_W-1:0]  source_vector_p1,
    input  wire logic                        mask_even,
    input  wire logic                        mask_odd,
    input  wire logic [vsu_pkg::DATA_W-1:0]  vector_count_register_p0,
    input  wire logic                        vector_count_ovf_p0,
    input  wire logic [vsu_pkg::DATA_W-1:0]  vector_count_register_p1,
    input  wire logic                        vector_count_ovf_p1,
    output logic                             in_ready,
    output logic                             busy,
    output logic                             no_ak_overflow,
    output logic                             res_p0_valid,
    output logic [vsu_pkg::DATA_W-1:0]       destination_vector_p0,
    output logic [vsu_pkg::VL_W-1:0]         res_p0_idx,
    output logic                             res_p1_valid,
    output logic [vsu_pkg::DATA_W-1:0]       destination_vector_p1,
    output logic [vsu_pkg::VL_W-1:0]         res_p1_idx,
    output logic [vsu_pkg::VL_W-1:0]         src_count,
    output logic                             shift_end
);
    localparam int DW = vsu_pkg::DATA_W;
    localparam int CW = vsu_pkg::CNT_W;
    localparam int VW = vsu_pkg::VL_W;

    function automatic logic mode_single(input vsu_pkg::vsu_mode_t m);
        mode_single = (m == vsu_pkg::MD_LSH) || (m == vsu_pkg::MD_RSH);
    endfunction : mode_single

    function automatic logic mode_right(input vsu_pkg::vsu_mode_t m);
        mode_right = (m == vsu_pkg::MD_RSH) || (m == vsu_pkg::MD_RDBL);
    endfunction : mode_right

    vsu_pkg::vsu_state_t state_ff;
    vsu_pkg::vsu_state_t nxt_state;
    vsu_pkg::vsu_mode_t  mode_ff;
    vsu_pkg::vsu_mode_t  go_mode;
    logic                use_v0_ff;
    logic [CW-1:0]       ak_cnt_ff;
    logic                ak_ovs_ff;
    logic [VW-1:0]       vl_ff;
    logic [VW-1:0]       pos_ff;
    logic [VW-1:0]       dst_ff;
    logic [VW-1:0]       src_ff;
    logic [DW-1:0]       prev_ff;
    logic [DW-1:0]       pend0_ff;
    logic [DW-1:0]       pend1_ff;
    logic                pend_v0_ff;
    logic                pend_v1_ff;
    logic                nxt_v0;
    logic                nxt_v1;
    logic [DW-1:0]       nxt_d0;
    logic [DW-1:0]       nxt_d1;
    logic                nxt_end;

    // Decode of the issued instruction
    wire go_take  = ce && go && (state_ff == vsu_pkg::ST_IDLE); // RULE17
    wire alt_form = extended_instruction_prefix; // RULE17
    wire go_v0    = alt_form && (op_sel == vsu_pkg::OP_LEFT_SGL ||
                    op_sel == vsu_pkg::OP_RIGHT_SGL) &&
                    (k_field == vsu_pkg::K_ZERO);
    // Overshift looks at every operand bit above the count field, bits 7 up
    wire go_ovs   = |address_count_register[DW-1:vsu_pkg::OVS_LSB]; // RULE1
    assign go_mode =
        (alt_form && op_sel == vsu_pkg::OP_LEFT_DBL)  ? vsu_pkg::MD_XFER :
        (alt_form && op_sel == vsu_pkg::OP_RIGHT_DBL) ?
            (k_field[0] ? vsu_pkg::MD_EXPD : vsu_pkg::MD_CMPR) :
        (op_sel == vsu_pkg::OP_LEFT_SGL)  ? vsu_pkg::MD_LSH  :
        (op_sel == vsu_pkg::OP_RIGHT_SGL) ? vsu_pkg::MD_RSH  :
        (op_sel == vsu_pkg::OP_LEFT_DBL)  ? vsu_pkg::MD_LDBL :
                                            vsu_pkg::MD_RDBL;

    // Element acceptance and progress
    wire run     = (state_ff == vsu_pkg::ST_RUN);
    wire flush   = (state_ff == vsu_pkg::ST_FLUSH);
    wire v0      = source_vector_p0_valid;
    wire v1      = source_vector_p1_valid;
    wire acc     = ce && run && (v0 || v1); // RULE18
    wire ld      = (mode_ff == vsu_pkg::MD_LDBL);
    wire [1:0] n_in    = {1'b0, v0} + {1'b0, v1};
    wire [VW:0] pos_sum = {1'b0, pos_ff} + {{(VW-1){1'b0}}, n_in};
    wire last    = (pos_sum >= {1'b0, vl_ff});
    wire m0      = v0 && mask_even;
    wire m1      = v1 && mask_odd;
    wire [1:0] n_set   = {1'b0, m0} + {1'b0, m1};

    assign in_ready = run;
    assign busy     = !(state_ff == vsu_pkg::ST_IDLE);
    assign src_count = src_ff;

    // Shifter operands per pipe; left doubles run one pair behind so
    // each element can meet its successor as the low half
    logic [DW-1:0] opa [0:1];
    logic [DW-1:0] opb [0:1];
    logic [DW-1:0] shres [0:1];
    assign opa[0] = ld ? pend0_ff : prev_ff; // RULE11 RULE12
    assign opb[0] = ld ? (pend_v1_ff ? pend1_ff : {DW{1'b0}})
                       : source_vector_p0;
    assign opa[1] = ld ? pend1_ff : source_vector_p0; // RULE12
    assign opb[1] = ld ? ((run && v0) ? source_vector_p0 : {DW{1'b0}})
                       : source_vector_p1;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pipe
            wire [DW-1:0] vcnt = (gi == 0) ? vector_count_register_p0
                                           : vector_count_register_p1;
            wire          vovf = (gi == 0) ? vector_count_ovf_p0
                                           : vector_count_ovf_p1;
            wire [CW-1:0] raw  = use_v0_ff ? vcnt[CW-1:0] : ak_cnt_ff; // RULE9
            wire          ovs  = use_v0_ff ?
                (vovf || (|vcnt[DW-1:vsu_pkg::OVS_LSB])) : ak_ovs_ff; // RULE19 RULE20
            // Sum of weighted bits is just the binary value
            wire [CW-1:0] cnt  = mode_single(mode_ff) ?
                {1'b0, raw[vsu_pkg::SGL_W-1:0]} : raw; // RULE4 RULE5 RULE6
            wire          zero = ovs || (cnt == {CW{1'b0}}); // RULE7
            // Right shifts reuse the left shifter with the complement count
            wire [CW-1:0] amt  = mode_right(mode_ff) ?
                CW'({CW{1'b0}} - cnt) : cnt; // RULE8
            wire [vsu_pkg::WIN_W-1:0] win =
                (mode_ff == vsu_pkg::MD_LSH)  ? {opb[gi], {2*DW{1'b0}}} :
                (mode_ff == vsu_pkg::MD_RSH)  ? {{2*DW{1'b0}}, opb[gi]} :
                (mode_ff == vsu_pkg::MD_LDBL) ? {opa[gi], opb[gi], {DW{1'b0}}}
                                              : {{DW{1'b0}}, opa[gi], opb[gi]}; // RULE10
            wire [DW-1:0] up;
            vsu_left_shifter u_shift (
                .window (win),
                .amount (amt),
                .upper  (up)
            ); // RULE8
            assign shres[gi] = zero ? {DW{1'b0}} : up; // RULE7 RULE19
        end
    endgenerate

    // Result selection per mode
    always_comb begin
        nxt_state = state_ff;
        nxt_v0    = 1'b0;
        nxt_v1    = 1'b0;
        nxt_d0    = destination_vector_p0;
        nxt_d1    = destination_vector_p1;
        nxt_end   = 1'b0;
        case (state_ff)
            vsu_pkg::ST_IDLE: begin
                if (go_take) begin
                    if (vec_len == {VW{1'b0}}) begin
                        nxt_end = 1'b1; // RULE16
                    end else begin
                        nxt_state = vsu_pkg::ST_RUN;
                    end
                end
            end
            vsu_pkg::ST_RUN: begin
                if (acc) begin
                    case (mode_ff)
                        vsu_pkg::MD_LDBL: begin
                            nxt_v0 = pend_v0_ff;
                            nxt_v1 = pend_v1_ff;
                            nxt_d0 = shres[0];
                            nxt_d1 = shres[1];
                        end
                        vsu_pkg::MD_XFER: begin
                            nxt_v0 = v0;
                            nxt_v1 = v1;
                            nxt_d0 = source_vector_p0;
                            nxt_d1 = source_vector_p1;
                        end
                        vsu_pkg::MD_CMPR: begin
                            nxt_v0 = m0 || m1; // RULE13
                            nxt_v1 = m0 && m1;
                            nxt_d0 = m0 ? source_vector_p0 : source_vector_p1;
                            nxt_d1 = source_vector_p1;
                        end
                        vsu_pkg::MD_EXPD: begin
                            nxt_v0 = v0; // RULE14
                            nxt_v1 = v1;
                            nxt_d0 = m0 ? source_vector_p0 : {DW{1'b0}};
                            nxt_d1 = !m1 ? {DW{1'b0}} :
                                     m0 ? source_vector_p1 : source_vector_p0;
                        end
                        default: begin
                            nxt_v0 = v0; // RULE15 RULE18
                            nxt_v1 = v1;
                            nxt_d0 = shres[0];
                            nxt_d1 = shres[1];
                        end
                    endcase
                    if (last) begin
                        nxt_end   = !ld; // RULE16
                        nxt_state = ld ? vsu_pkg::ST_FLUSH : vsu_pkg::ST_IDLE;
                    end
                end
            end
            vsu_pkg::ST_FLUSH: begin
                if (ce) begin
                    nxt_v0    = pend_v0_ff; // RULE18
                    nxt_v1    = pend_v1_ff;
                    nxt_d0    = shres[0];
                    nxt_d1    = shres[1];
                    nxt_end   = 1'b1; // RULE16
                    nxt_state = vsu_pkg::ST_IDLE;
                end
            end
            default: nxt_state = vsu_pkg::ST_IDLE;
        endcase
    end

    // Counter advance: compress counts results, expand counts set bits
    wire cmpr = (mode_ff == vsu_pkg::MD_CMPR);
    wire expd = (mode_ff == vsu_pkg::MD_EXPD);
    wire [1:0] n_out = cmpr ? n_set : n_in; // RULE13
    wire [1:0] n_src = expd ? n_set : n_in; // RULE14
    wire [1:0] n_fl  = {1'b0, pend_v0_ff} + {1'b0, pend_v1_ff};
    wire [1:0] n_ld  = n_fl;
    wire [1:0] n_dst = flush ? n_fl : (ld ? n_ld : n_out);
    wire dst_step    = (acc && !(ld && !pend_v0_ff)) || (ce && flush);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= vsu_pkg::ST_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            res_p0_valid          <= 1'b0;
            res_p1_valid          <= 1'b0;
            destination_vector_p0 <= {DW{1'b0}};
            destination_vector_p1 <= {DW{1'b0}};
            res_p0_idx            <= {VW{1'b0}};
            res_p1_idx            <= {VW{1'b0}};
            shift_end             <= 1'b0;
        end else if (ce) begin
            res_p0_valid          <= nxt_v0; // RULE15
            res_p1_valid          <= nxt_v1; // RULE15
            destination_vector_p0 <= nxt_d0;
            destination_vector_p1 <= nxt_d1;
            res_p0_idx            <= dst_ff;
            res_p1_idx            <= VW'(dst_ff + 1'b1);
            shift_end             <= nxt_end;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_ff        <= vsu_pkg::MD_LSH;
            use_v0_ff      <= 1'b0;
            ak_cnt_ff      <= {CW{1'b0}};
            ak_ovs_ff      <= 1'b0;
            no_ak_overflow <= 1'b0;
            vl_ff          <= {VW{1'b0}};
        end else if (go_take) begin
            mode_ff        <= go_mode;
            use_v0_ff      <= go_v0;
            ak_cnt_ff      <= address_count_register[CW-1:0]; // RULE3
            ak_ovs_ff      <= go_ovs; // RULE1
            no_ak_overflow <= !go_ovs; // RULE2
            vl_ff          <= vec_len;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pos_ff <= {VW{1'b0}};
            dst_ff <= {VW{1'b0}};
            src_ff <= {VW{1'b0}};
        end else if (go_take) begin
            pos_ff <= {VW{1'b0}}; // RULE13 RULE14
            dst_ff <= {VW{1'b0}};
            src_ff <= {VW{1'b0}};
        end else if (ce) begin
            if (acc) begin
                pos_ff <= pos_sum[VW-1:0];
                src_ff <= VW'(src_ff + {{(VW-2){1'b0}}, n_src}); // RULE14
            end
            if (dst_step) begin
                dst_ff <= VW'(dst_ff + {{(VW-2){1'b0}}, n_dst}); // RULE13
            end
        end
    end

    // Pair history for the double shifts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_ff    <= {DW{1'b0}};
            pend0_ff   <= {DW{1'b0}};
            pend1_ff   <= {DW{1'b0}};
            pend_v0_ff <= 1'b0;
            pend_v1_ff <= 1'b0;
        end else if (go_take) begin
            prev_ff    <= {DW{1'b0}}; // RULE11
            pend_v0_ff <= 1'b0;
            pend_v1_ff <= 1'b0;
        end else if (acc) begin
            prev_ff    <= v1 ? source_vector_p1 : source_vector_p0; // RULE12
            pend0_ff   <= source_vector_p0;
            pend1_ff   <= source_vector_p1;
            pend_v0_ff <= v0;
            pend_v1_ff <= v1;
        end else if (ce && flush) begin
            pend_v0_ff <= 1'b0;
            pend_v1_ff <= 1'b0;
        end
    end
endmodule : vsu_shift_unit
`default_nettype wire

// ===== vsu_shift_unit_monitor.sv
// Port checker for the vector shift unit, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module vsu_shift_unit_monitor (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        go,
    input wire logic        extended_instruction_prefix,
    input wire logic [1:0]  op_sel,
    input wire logic [2:0]  k_field,
    input wire logic [7:0]  vec_len,
    input wire logic [63:0] address_count_register,
    input wire logic        source_vector_p0_valid,
    input wire logic        vector_count_ovf_p0,
    input wire logic        in_ready,
    input wire logic        busy,
    input wire logic        no_ak_overflow,
    input wire logic        res_p0_valid,
    input wire logic [63:0] destination_vector_p0,
    input wire logic [7:0]  res_p0_idx,
    input wire logic        res_p1_valid,
    input wire logic [7:0]  res_p1_idx,
    input wire logic        shift_end
);
    logic zero_ff;
    logic vmode_ff;
    wire  start  = ce && go && !busy;
    wire  ak_big = address_count_register[63:7] != 57'h0;
    wire  ak_nil = op_sel[1] ? address_count_register[6:0] == 7'h0
                             : address_count_register[5:0] == 6'h0;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Class of the running operation, captured when it is taken
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            zero_ff  <= 1'b0;
            vmode_ff <= 1'b0;
        end else if (start) begin
            zero_ff  <= !extended_instruction_prefix && (ak_big || ak_nil);
            vmode_ff <= extended_instruction_prefix && !op_sel[1]
                        && k_field == 3'h0;
        end
    end
    a_start_runs: assert property (
        start && vec_len != 8'h00 |=> busy && in_ready)
        else $error("start not taken");
    a_empty_ends: assert property (
        start && vec_len == 8'h00 |=> shift_end && !busy)
        else $error("empty operation did not end");
    a_flag_set: assert property (
        start |=> no_ak_overflow == !$past(ak_big))
        else $error("overshift flag wrong");
    a_flag_holds: assert property (!start |=> $stable(no_ak_overflow))
        else $error("overshift flag moved");
    a_pipe_pair: assert property (
        res_p1_valid |-> res_p0_valid && res_p1_idx == res_p0_idx + 8'h01)
        else $error("pipe pair broken");
    a_end_idle: assert property (shift_end |-> !busy && !in_ready)
        else $error("end while running");
    a_ready_busy: assert property (in_ready |-> busy)
        else $error("intake open while idle");
    a_forced_zero: assert property (
        res_p0_valid && zero_ff |-> destination_vector_p0 == 64'h0)
        else $error("result not cleared");
    a_vec_ovf: assert property (
        res_p0_valid && vmode_ff && $past(ce && in_ready
        && source_vector_p0_valid && vector_count_ovf_p0)
        |-> destination_vector_p0 == 64'h0)
        else $error("count overflow not cleared");
endmodule : vsu_shift_unit_monitor
bind vsu_shift_unit vsu_shift_unit_monitor vsu_shift_unit_monitor_i (
    .core_clk(core_clk), .rst(rst), .ce(ce), .go(go),
    .extended_instruction_prefix(extended_instruction_prefix),
    .op_sel(op_sel), .k_field(k_field), .vec_len(vec_len),
    .address_count_register(address_count_register),
    .source_vector_p0_valid(source_vector_p0_valid),
    .vector_count_ovf_p0(vector_count_ovf_p0), .in_ready(in_ready),
    .busy(busy), .no_ak_overflow(no_ak_overflow),
    .res_p0_valid(res_p0_valid), .res_p0_idx(res_p0_idx),
    .destination_vector_p0(destination_vector_p0),
    .res_p1_valid(res_p1_valid), .res_p1_idx(res_p1_idx),
    .shift_end(shift_end));
`default_nettype wire

// ===== vsu_shift_unit_unused.sv
// Intentionally empty: no further design content
`default_nettype none
`default_nettype wire

// ===== vsu_supplier.sv
// Register and mask side model feeding element pairs to the unit
`timescale 1ns/10ps
`default_nettype none
module vsu_supplier (
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic       busy,
    input  wire logic       in_ready,
    input  wire logic [7:0] vl,
    input  wire logic [7:0] src_count,
    output logic            p0_valid,
    output logic [63:0]     p0,
    output logic            p1_valid,
    output logic [63:0]     p1,
    output logic            mask_even,
    output logic            mask_odd,
    output logic [63:0]     vc0,
    output logic            ovf0,
    output logic [63:0]     vc1,
    output logic            ovf1
);
    logic [63:0] mem [0:130];
    logic        msk [0:130];
    logic [63:0] vc  [0:130];
    logic        expand = 1'b0;
    logic        ovf_on = 1'b0;
    logic        rdy_d  = 1'b0;
    int          pos    = 0;
    int          at     = 0;
    int          rd     = 0;
    int          cyc    = 0;
    // Outputs move a step after the edge so the unit never sees a race
    always @(posedge core_clk) begin
        if (go && !busy)
            pos <= 0;
        else if (in_ready && p0_valid)
            pos <= pos + (p1_valid ? 2 : 1);
        cyc <= cyc + 1;
        #1;
        at = pos;
        rd = expand ? int'(src_count) : pos;
        rdy_d = in_ready;
    end
    assign p0_valid  = rdy_d && at < int'(vl);
    assign p1_valid  = rdy_d && at + 1 < int'(vl);
    // Released pipes carry a pattern that changes every cycle
    assign p0        = p0_valid ? mem[rd] : {cyc, ~cyc};
    assign p1        = p1_valid ? mem[rd + 1] : {~cyc, cyc};
    assign mask_even = p0_valid && msk[at];
    assign mask_odd  = p1_valid && msk[at + 1];
    assign vc0       = p0_valid ? vc[at] : {cyc, cyc};
    assign vc1       = p1_valid ? vc[at + 1] : {~cyc, ~cyc};
    assign ovf0      = p0_valid && ovf_on && at == 4;
    assign ovf1      = p1_valid && ovf_on && at + 1 == 4;
endmodule : vsu_supplier
`default_nettype wire
